// [shared/pis_pkg.sv]
/*
  Package for the peripheral interrupt-source block: register offsets, field
  positions, reset values, vector address and the carrier structs.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pis_pkg;
  // Register offsets on the plain register port.
  localparam logic [8:0] PIS_ADDR_IRQ_CONTROL = 9'h00b;
  localparam logic [8:0] PIS_ADDR_OPTION      = 9'h081;
  localparam logic [8:0] PIS_ADDR_TIMER       = 9'h001;
  // Field positions inside the interrupt control register.
  localparam int PIS_BIT_PORT_CHANGE_FLAG  = 0;
  localparam int PIS_BIT_EDGE_EVENT_FLAG   = 1;
  localparam int PIS_BIT_TIMER_OVF_FLAG    = 2;
  localparam int PIS_BIT_PORT_CHANGE_EN    = 3;
  localparam int PIS_BIT_EDGE_EVENT_EN     = 4;
  localparam int PIS_BIT_TIMER_OVF_EN      = 5;
  localparam int PIS_BIT_PERIPH_EN         = 6;
  localparam int PIS_BIT_GLOBAL_EN         = 7;
  // Field position inside the option register.
  localparam int PIS_BIT_EDGE_POLARITY     = 6;
  // Reset values.
  localparam logic [7:0] PIS_RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] PIS_RST_OPTION      = 8'hff;
  localparam logic [7:0] PIS_RST_TIMER       = 8'h00;
  // Vector address and stack shape.
  localparam logic [12:0] PIS_IRQ_VECTOR   = 13'h0004;
  localparam int          PIS_STACK_DEPTH  = 8;
  localparam int          PIS_PC_WIDTH     = 13;

  // Register port request.
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pis_reg_req_t;

  // Core control strobes.
  typedef struct packed {
    logic        halt_enter;
    logic        retfie;
    logic        call_push;
    logic        ret_pop;
    logic        timer_tick;
    logic [12:0] pc_next;
  } pis_core_req_t;
endpackage : pis_pkg
`default_nettype wire

// [hw/pis_irq_sources.sv]
/*
  Interrupt-source block: timer overflow, external edge pin, port-B change
  detector, masking, wake from halt, vectoring and the return stack.
  Assumes the core drives one-cycle strobes on clk_sys and pins are async.
*/
// The strobed register port was left to the implementer.
// Operation
// RQ1 - Timer count rolling from all ones to zero sets timer overflow flag, bit 2.
// RQ2 - Timer overflow raises no request while its enable, bit 5, is zero.
// RQ3 - Timer overflow flag stays set until software clears it.
// RQ4 - Timer overflow never wakes the core from halt; timer stops then.
// RQ5 - Edge pin triggers on rising edge if polarity bit set, else falling.
// RQ6 - A selected edge on the pin sets the edge event flag, bit 1.
// RQ7 - Edge pin request suppressed while edge event enable, bit 4, clear.
// RQ8 - Edge event flag stays set until software clears it.
// RQ9 - Edge event wakes halt only if its enable was set before halting.
// RQ10 - After wake, branch to vector only if global enable set, else continue.
// RQ11 - Any level change on port B pins 7 to 4 sets port change flag.
// RQ12 - Port change request allowed only while its enable bit is set.
// RQ13 - Taking an interrupt saves only the return program counter on the stack.
// RQ14 - Flags set on events regardless of own enable and global enable.
// RQ15 - Return stack is eight deep, thirteen bits wide, pointer hidden.
// RQ16 - Request to core when any flag and its enable and global enable set.
// RQ17 - Vectoring clears global enable; return from interrupt sets it again.
`timescale 1ns/1ps
`default_nettype none
module pis_irq_sources
  import pis_pkg::*;
#(
  parameter int STACK_DEPTH = PIS_STACK_DEPTH
) (
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // Register port.
  input  wire pis_pkg::pis_reg_req_t reg_req,
  output logic [7:0]              reg_rdata,
  // Pins.
  input  wire logic               edge_irq_pin,
  input  wire logic [7:4]         port_b_pins,
  // Core side.
  input  wire pis_pkg::pis_core_req_t core_req,
  output logic                    irq_request,
  output logic                    vector_take,
  output logic [12:0]             vector_pc,
  output logic [12:0]             return_pc,
  output logic                    halted,
  output logic                    wake_pulse,
  output logic                    irq_out
);
  import pis_pkg::*;

  logic [7:0]  ctrl_r;
  logic [7:0]  option_r;
  logic [7:0]  timer_count_r;
  logic [2:0]  pin_sync_r;
  logic [2:0]  pb_sync_r [7:4];
  logic        pin_state_r;
  logic [7:4]  pb_state_r;
  logic        halt_r;
  logic        edge_en_at_halt_r;
  logic [12:0] stack_r [STACK_DEPTH];
  logic [2:0]  sp_r;
  logic [2:0]  sp_top;
  logic        pin_agree;
  logic        pin_now;
  logic [7:4]  pb_now;
  logic [7:4]  pb_agree;
  logic        edge_hit;
  logic        pb_change;
  logic        timer_ovf;
  logic        ctrl_wr;
  logic [2:0]  pending;
  logic        wake;

  // Pin synchronisers: three stages; a change counts when stages two and three agree.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], edge_irq_pin};
    end
  end

  genvar g;
  generate
    for (g = 4; g < 8; g++) begin : g_pb_sync
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pb_sync_r[g] <= 3'h0;
        end else begin
          pb_sync_r[g] <= {pb_sync_r[g][1:0], port_b_pins[g]};
        end
      end
      assign pb_agree[g] = (pb_sync_r[g][1] == pb_sync_r[g][2]);
      assign pb_now[g]   = pb_sync_r[g][2];
    end
  endgenerate

  assign pin_agree = (pin_sync_r[1] == pin_sync_r[2]);
  assign pin_now   = pin_sync_r[2];

  // Debounced pin levels; the reset level is zero so a pin held high at reset
  // may report one spurious change after release.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_state_r <= 1'b0;
      pb_state_r  <= 4'h0;
    end else begin
      if (pin_agree) begin
        pin_state_r <= pin_now;
      end
      for (int i = 4; i < 8; i++) begin
        if (pb_agree[i]) begin
          pb_state_r[i] <= pb_now[i];
        end
      end
    end
  end

  // Edge detection with selectable polarity.
  always_comb begin
    edge_hit = 1'b0;
    if (pin_agree && (pin_now != pin_state_r)) begin
      edge_hit = option_r[PIS_BIT_EDGE_POLARITY] ? pin_now : !pin_now; // RQ5
    end
  end

  // Any settled level change on the upper port pins.
  always_comb begin
    pb_change = 1'b0;
    for (int i = 4; i < 8; i++) begin
      if (pb_agree[i] && (pb_now[i] != pb_state_r[i])) begin
        pb_change = 1'b1; // RQ11
      end
    end
  end

  // Timer count; it stands still while halted, so it cannot overflow then.
  assign timer_ovf = core_req.timer_tick && !halt_r && (timer_count_r == 8'hff); // RQ1 RQ4

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_count_r <= PIS_RST_TIMER;
    end else if (reg_req.wr && reg_req.addr == PIS_ADDR_TIMER) begin
      timer_count_r <= reg_req.wdata;
    end else if (core_req.timer_tick && !halt_r) begin
      timer_count_r <= timer_count_r + 8'h01;
    end
  end

  // Option register, software only.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      option_r <= PIS_RST_OPTION;
    end else if (reg_req.wr && reg_req.addr == PIS_ADDR_OPTION) begin
      option_r <= reg_req.wdata;
    end
  end

  assign ctrl_wr = reg_req.wr && (reg_req.addr == PIS_ADDR_IRQ_CONTROL);

  // Flags and enables; a hardware set wins over a software clear in the same
  // cycle so no event is lost.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= PIS_RST_IRQ_CONTROL;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= reg_req.wdata;
      end
      if (vector_take) begin
        ctrl_r[PIS_BIT_GLOBAL_EN] <= 1'b0; // RQ17
      end else if (core_req.retfie) begin
        ctrl_r[PIS_BIT_GLOBAL_EN] <= 1'b1; // RQ17
      end
      if (timer_ovf) begin
        ctrl_r[PIS_BIT_TIMER_OVF_FLAG] <= 1'b1; // RQ1 RQ3 RQ14
      end
      if (edge_hit) begin
        ctrl_r[PIS_BIT_EDGE_EVENT_FLAG] <= 1'b1; // RQ6 RQ8 RQ14
      end
      if (pb_change) begin
        ctrl_r[PIS_BIT_PORT_CHANGE_FLAG] <= 1'b1; // RQ11 RQ14
      end
    end
  end

  // Per-source pending terms, each gated by its own enable.
  assign pending[0] = ctrl_r[PIS_BIT_PORT_CHANGE_FLAG] && ctrl_r[PIS_BIT_PORT_CHANGE_EN]; // RQ12
  assign pending[1] = ctrl_r[PIS_BIT_EDGE_EVENT_FLAG] && ctrl_r[PIS_BIT_EDGE_EVENT_EN];   // RQ7
  assign pending[2] = ctrl_r[PIS_BIT_TIMER_OVF_FLAG] && ctrl_r[PIS_BIT_TIMER_OVF_EN];     // RQ2

  assign irq_request = (|pending) && ctrl_r[PIS_BIT_GLOBAL_EN]; // RQ16
  assign irq_out     = irq_request;

  // Wake sources: the edge only when enabled at halt entry, the port change
  // when enabled; the timer is deliberately absent.
  assign wake = halt_r && ((ctrl_r[PIS_BIT_EDGE_EVENT_FLAG] && edge_en_at_halt_r) // RQ9
                           || pending[0]); // RQ4

  // Halt state and the enable snapshot taken on entry.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      halt_r            <= 1'b0;
      edge_en_at_halt_r <= 1'b0;
    end else if (wake) begin
      halt_r <= 1'b0;
    end else if (core_req.halt_enter && !halt_r) begin
      halt_r            <= 1'b1;
      edge_en_at_halt_r <= ctrl_r[PIS_BIT_EDGE_EVENT_EN]; // RQ9
    end
  end

  assign halted     = halt_r;
  assign wake_pulse = wake;
  // After a wake the core vectors only with global enable set; otherwise it
  // simply resumes at the next instruction.
  assign vector_take = irq_request && !core_req.halt_enter; // RQ10
  assign vector_pc   = PIS_IRQ_VECTOR;

  // Return stack: circular, a ninth push overwrites the oldest entry, and the
  // pointer is never visible to software.
  assign sp_top = sp_r - 3'h1;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sp_r <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= 13'h0000;
      end
    end else if (vector_take || core_req.call_push) begin
      stack_r[sp_r] <= core_req.pc_next; // RQ13 RQ15
      sp_r          <= sp_r + 3'h1;
    end else if (core_req.ret_pop || core_req.retfie) begin
      sp_r <= sp_top; // RQ15
    end
  end

  assign return_pc = stack_r[sp_top];

  // Register read data, one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        PIS_ADDR_IRQ_CONTROL: reg_rdata <= ctrl_r;
        PIS_ADDR_OPTION:      reg_rdata <= option_r;
        PIS_ADDR_TIMER:       reg_rdata <= timer_count_r;
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : pis_irq_sources
`default_nettype wire

// [verif/pis_irq_sources_props.sv]
/* Checker for the interrupt-source block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pis_irq_sources_props
  import pis_pkg::*;
#(parameter int STACK_DEPTH = PIS_STACK_DEPTH) (
  // Clock, reset and register port.
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  input wire pis_pkg::pis_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  // Pins and core side.
  input wire logic                  edge_irq_pin,
  input wire logic [7:4]            port_b_pins,
  input wire pis_pkg::pis_core_req_t core_req,
  input wire logic                  irq_request,
  input wire logic                  vector_take,
  input wire logic [12:0]           vector_pc,
  input wire logic [12:0]           return_pc,
  input wire logic                  halted,
  input wire logic                  wake_pulse,
  input wire logic                  irq_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // A wake ends the halt in the very next cycle.
  sequence s_wake; halted ##1 !halted; endsequence
  sequence s_ctrl_rd; reg_req.rd && reg_req.addr == PIS_ADDR_IRQ_CONTROL; endsequence
  a_irq_from_ctrl: assert property (s_ctrl_rd |=>
    ((reg_rdata[7] && |(reg_rdata[2:0] & reg_rdata[5:3])) == $past(irq_request))) else $error("irq mismatch");
  a_irq_out_same: assert property (irq_out == irq_request) else $error("irq_out differs");
  a_vector_gate: assert property (vector_take |-> irq_request && !core_req.halt_enter)
    else $error("bad vector");
  a_vector_clears_ge: assert property (vector_take && !reg_req.wr |=> !irq_request)
    else $error("global enable kept");
  a_vector_addr: assert property (vector_pc == PIS_IRQ_VECTOR) else $error("vector address");
  a_push_return: assert property (vector_take |=> return_pc == $past(core_req.pc_next))
    else $error("return pc lost");
  a_wake_ends: assert property (wake_pulse |-> s_wake) else $error("wake without halt end");
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
endmodule : pis_irq_sources_props
bind pis_irq_sources pis_irq_sources_props #(.STACK_DEPTH(STACK_DEPTH)) u_props (.clk_sys(clk_sys), .rstn(rstn),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .edge_irq_pin(edge_irq_pin), .port_b_pins(port_b_pins),
  .core_req(core_req), .irq_request(irq_request), .vector_take(vector_take), .vector_pc(vector_pc),
  .return_pc(return_pc), .halted(halted), .wake_pulse(wake_pulse), .irq_out(irq_out));
`default_nettype wire

// [verif/pis_core_model.sv]
/* Model of the core's vectoring side: turns bench commands into strobes.
   Assumes one-cycle command pulses from the bench on clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module pis_core_model
  import pis_pkg::*;
(
  // Clock, reset and commands.
  input wire logic            clk_sys,
  input wire logic            rstn,
  input wire logic            tick_req,
  input wire logic            halt_req,
  input wire logic            ret_req,
  input wire logic            vector_take,
  // Strobes to the block.
  output pis_pkg::pis_core_req_t core_req
);
  // The fetch address runs on, and jumps to the vector when one is taken.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_req <= '0;
    end else begin
      core_req.halt_enter <= halt_req;
      core_req.retfie     <= ret_req;
      core_req.timer_tick <= tick_req;
      core_req.pc_next    <= vector_take ? PIS_IRQ_VECTOR : core_req.pc_next + 13'h0001;
    end
  end
endmodule : pis_core_model
`default_nettype wire

// [verif/pis_irq_sources_bench.sv]
/* Self-checking bench for the interrupt-source block.
   Assumes the core model file and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module pis_irq_sources_bench;
  import pis_pkg::*;
  logic clk_sys, rstn, edge_irq_pin, tick_req, halt_req, ret_req, rd_seen;
  logic irq_request, vector_take, halted, wake_pulse, irq_out;
  logic [7:4] port_b_pins;
  logic [7:0] reg_rdata;
  logic [12:0] vector_pc, return_pc;
  pis_reg_req_t reg_req;
  pis_core_req_t core_req;
  int mismatches, check_count, cycles;
  logic [7:0] exp_q[$];
  localparam logic [8:0] CTL = PIS_ADDR_IRQ_CONTROL;
  pis_irq_sources i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .edge_irq_pin(edge_irq_pin), .port_b_pins(port_b_pins), .core_req(core_req), .irq_request(irq_request),
    .vector_take(vector_take), .vector_pc(vector_pc), .return_pc(return_pc), .halted(halted),
    .wake_pulse(wake_pulse), .irq_out(irq_out));
  pis_core_model i_core (.clk_sys(clk_sys), .rstn(rstn), .tick_req(tick_req), .halt_req(halt_req),
    .ret_req(ret_req), .vector_take(vector_take), .core_req(core_req));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : wr
  // The expected value is queued when the read is issued.
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
  endtask : rd
  task automatic go(input logic t, input logic h, input logic r);
    @(posedge clk_sys);
    {tick_req, halt_req, ret_req} <= {t, h, r};
    @(posedge clk_sys);
    {tick_req, halt_req, ret_req} <= 3'b000;
    repeat (3) @(posedge clk_sys);
  endtask : go
  // Pins pass a three-edge filter, so six cycles leave margin.
  task automatic pin(input logic v);
    @(posedge clk_sys);
    edge_irq_pin <= v;
    repeat (6) @(posedge clk_sys);
  endtask : pin
  task automatic chk_halt(input logic exp);
    #1 check("halted", {7'h00, halted}, {7'h00, exp});
  endtask : chk_halt
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_sys) rd_seen <= reg_req.rd;
  always @(negedge clk_sys) if (rd_seen) check("reg_rdata", reg_rdata, exp_q.pop_front());
  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {rstn, edge_irq_pin, tick_req, halt_req, ret_req, rd_seen} = 6'b0;
    reg_req = '0;
    port_b_pins = 4'h0;
    {mismatches, check_count, cycles} = '0;
    void'($urandom(32'hb0ae));
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(CTL, PIS_RST_IRQ_CONTROL);
    rd(PIS_ADDR_OPTION, PIS_RST_OPTION);
    rd(9'h1ff, 8'h00);
    $display("test reset done");
    wr(PIS_ADDR_TIMER, 8'hff);
    go(1'b1, 1'b0, 1'b0);
    rd(CTL, 8'h04);
    wr(CTL, 8'ha4);
    rd(CTL, 8'h24);
    wr(CTL, 8'h20);
    go(1'b0, 1'b0, 1'b1);
    rd(CTL, 8'ha0);
    $display("test timer done");
    for (int p = 1; p >= 0; p--) begin
      wr(PIS_ADDR_OPTION, p ? 8'hff : 8'hbf);
      wr(CTL, 8'h00);
      pin(1'b1);
      rd(CTL, p ? 8'h02 : 8'h00);
      rd(CTL, p ? 8'h02 : 8'h00);
      wr(CTL, 8'h00);
      pin(1'b0);
      rd(CTL, p ? 8'h00 : 8'h02);
    end
    $display("test edge done");
    wr(CTL, 8'h00);
    port_b_pins <= port_b_pins ^ (4'h1 << $urandom_range(3, 0));
    repeat (6) @(posedge clk_sys);
    rd(CTL, 8'h01);
    wr(CTL, 8'h89);
    rd(CTL, 8'h09);
    $display("test port done");
    pin(1'b1);
    wr(CTL, 8'h30);
    go(1'b0, 1'b1, 1'b0);
    chk_halt(1'b1);
    go(1'b1, 1'b0, 1'b0);
    chk_halt(1'b1);
    pin(1'b0);
    chk_halt(1'b0);
    rd(CTL, 8'h32);
    wr(CTL, 8'hb2);
    rd(CTL, 8'h32);
    #1 check("irq_out", {7'h00, irq_out}, 8'h00);
    check("vector_pc", vector_pc[7:0], PIS_IRQ_VECTOR[7:0]);
    $display("test wake done");
    repeat (4) @(posedge clk_sys);
    results();
  end
endmodule : pis_irq_sources_bench
`default_nettype wire
